//--- core/hdsp_pkg.sv
// package: register map, field layouts, reset values and timing for the serial port
package hdsp_pkg;
  localparam int          CLK_HZ       = 40_000_000;
  localparam int          MODCLK_HZ    = 8_000_000;
  localparam logic [2:0]  PRESCALE     = 3'(CLK_HZ / MODCLK_HZ);
  localparam logic [4:0]  OVERSAMPLE   = 5'h10;
  localparam logic [4:0]  BIT_LAST     = OVERSAMPLE - 5'h01;
  localparam logic [4:0]  HALF_LAST    = (OVERSAMPLE >> 1) - 5'h01;
  localparam logic [4:0]  STOP15_LAST  = OVERSAMPLE + (OVERSAMPLE >> 1) - 5'h01;
  localparam logic [4:0]  STOP2_LAST   = 5'({1'b0, OVERSAMPLE} + {1'b0, OVERSAMPLE} - 6'h01);
  localparam int          ADDR_W       = 12;
  localparam logic [11:0] OFF_DATA     = 12'h000;
  localparam logic [11:0] OFF_CTRL     = 12'h004;
  localparam logic [11:0] OFF_DIV      = 12'h008;
  localparam logic [11:0] OFF_STATUS   = 12'h00C;
  localparam logic [15:0] DIV_RESET    = 16'h0034;
  localparam int          ST_RXVALID   = 0;
  localparam int          ST_TXBUSY    = 1;
  localparam int          ST_PARERR    = 2;
  localparam int          ST_FRMERR    = 3;
  localparam int          ST_BREAK     = 4;
  localparam int          ST_OVERRUN   = 5;

  typedef enum logic [1:0] {HDSP_PAR_NONE, HDSP_PAR_ODD, HDSP_PAR_EVEN, HDSP_PAR_RSVD}
    hdsp_parity_type;
  typedef enum logic [1:0] {HDSP_STOP_1, HDSP_STOP_15, HDSP_STOP_2, HDSP_STOP_2B}
    hdsp_stop_type;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} hdsp_tx_state_type;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} hdsp_rx_state_type;

  // ctrl register layout, bit 0 upward: wlen, parity, stop, break, rts, loopback
  typedef struct packed {
    logic            loopback;
    logic            rts;
    logic            send_break;
    hdsp_stop_type   stop;
    hdsp_parity_type parity;
    logic [1:0]      wlen;
  } hdsp_ctrl_type;
  localparam hdsp_ctrl_type CTRL_RESET = '0;

  typedef struct packed {
    logic overrun;
    logic brk;
    logic frm_err;
    logic par_err;
    logic rx_valid;
  } hdsp_flags_type;
endpackage

//--- core/hdsp_port.sv
// file: half-duplex asynchronous serial port with an apb register slave
//
// Function
// - idle transmitter holds its serial output at mark, logic one
// - every character starts with one start bit at logic zero
// - every character ends with a stop bit at logic one
// - data bits per character selectable as 5, 6, 7 or 8, both directions
// - parity bit sits after the last data bit, before stop, both directions
// - even parity makes data plus parity hold an even count of ones
// - odd parity makes data plus parity hold an odd count of ones
// - parity choices are odd, even or none; none sends and checks nothing
// - forced mark and forced space parity are not offered
// - receiver flags an error when received parity mismatches the setting
// - stop period selectable as 1, 1.5 or 2 bit times at logic one
// - break is sent and detected as space longer than one whole character
// - one shared line pair, so sending and receiving never overlap
// - nodes take turns driving the line to avoid contention
// - signalling rate equals bit rate, one bit per interval
// - host rts output selects transceiver direction, drive when set
// - loopback feeds transmit output to receiver and cuts the external path
// - bit rate is the 8 MHz module rate over sixteen times a 16-bit divisor
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/10ps
module hdsp_port (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [hdsp_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        line_rx,
  output logic                             line_tx,
  output logic                             line_drive_en
);

  typedef struct packed {
    hdsp_pkg::hdsp_ctrl_type     ctrl;
    logic [15:0]                 div;
    logic [2:0]                  pre_cnt;
    logic [15:0]                 div_cnt;
    logic                        tick;
    hdsp_pkg::hdsp_tx_state_type tx_st;
    logic [4:0]                  tx_cnt;
    logic [2:0]                  tx_idx;
    logic [7:0]                  tx_sh;
    logic [7:0]                  tx_hold;
    logic                        tx_par;
    logic                        tx_bit;
    logic                        rx_sync1;
    logic                        rx_sync2;
    logic                        rx_armed;
    hdsp_pkg::hdsp_rx_state_type rx_st;
    logic [4:0]                  rx_cnt;
    logic [2:0]                  rx_idx;
    logic [7:0]                  rx_sh;
    logic                        rx_acc;
    logic                        rx_pbit;
    logic [7:0]                  rx_data;
    hdsp_pkg::hdsp_flags_type    flags;
    logic                        pready;
    logic                        pslverr;
    logic [31:0]                 prdata;
    logic                        line_tx;
    logic                        drive_en;
  } hdsp_state_type;

  hdsp_state_type s;
  hdsp_state_type next_s;
  function automatic logic [7:0] hdsp_mask(input logic [1:0] wlen);
    hdsp_mask = 8'hFF >> (2'h3 - wlen);
  endfunction
  logic                     xfer;
  logic                     wr;
  logic                     rd;
  logic                     rx_src;
  logic                     par_on;
  logic                     par_odd;
  logic [4:0]               stop_last;
  logic [7:0]               rx_word;
  hdsp_pkg::hdsp_flags_type flag_set;

  // parity code 3 is not a forced parity: it behaves as none
  assign par_on    = s.ctrl.parity == hdsp_pkg::HDSP_PAR_ODD ||
                     s.ctrl.parity == hdsp_pkg::HDSP_PAR_EVEN;
  assign par_odd   = s.ctrl.parity == hdsp_pkg::HDSP_PAR_ODD;
  assign xfer      = psel && penable && s.pready;
  assign wr        = xfer && pwrite;
  assign rd        = xfer && !pwrite;
  // in loopback the receiver listens to the internal transmit bit only
  assign rx_src    = s.ctrl.loopback ? s.tx_bit : s.rx_sync2;
  assign rx_word   = s.rx_sh >> (2'h3 - s.ctrl.wlen);
  always_comb begin
    unique case (s.ctrl.stop)
      hdsp_pkg::HDSP_STOP_1:  stop_last = hdsp_pkg::BIT_LAST;
      hdsp_pkg::HDSP_STOP_15: stop_last = hdsp_pkg::STOP15_LAST;
      default:                stop_last = hdsp_pkg::STOP2_LAST;
    endcase
  end
  always_comb begin
    next_s   = s;
    flag_set = '0;
    next_s.rx_sync1 = line_rx;
    next_s.rx_sync2 = s.rx_sync1;

    // 40 MHz down to the 8 MHz module rate, then the divisor gives 16x bit rate
    next_s.tick = 1'b0;
    if (s.pre_cnt == hdsp_pkg::PRESCALE - 3'h1) begin
      next_s.pre_cnt = '0;
      if (s.div_cnt + 16'h0001 >= s.div) begin
        next_s.div_cnt = '0;
        next_s.tick    = 1'b1;
      end else begin
        next_s.div_cnt = s.div_cnt + 16'h0001;
      end
    end else begin
      next_s.pre_cnt = s.pre_cnt + 3'h1;
    end

    // transmitter
    if (s.tick) begin
      unique case (s.tx_st)
        hdsp_pkg::TX_IDLE: ;
        hdsp_pkg::TX_START: begin
          next_s.tx_cnt = s.tx_cnt + 5'h01;
          if (s.tx_cnt == hdsp_pkg::BIT_LAST) begin
            next_s.tx_cnt = '0;
            next_s.tx_idx = '0;
            next_s.tx_st  = hdsp_pkg::TX_DATA;
          end
        end
        hdsp_pkg::TX_DATA: begin
          next_s.tx_cnt = s.tx_cnt + 5'h01;
          if (s.tx_cnt == hdsp_pkg::BIT_LAST) begin
            next_s.tx_cnt = '0;
            next_s.tx_sh  = s.tx_sh >> 1;
            next_s.tx_idx = s.tx_idx + 3'h1;
            if (s.tx_idx == {1'b0, s.ctrl.wlen} + 3'h4) begin
              next_s.tx_st = par_on ? hdsp_pkg::TX_PAR : hdsp_pkg::TX_STOP;
            end
          end
        end
        hdsp_pkg::TX_PAR: begin
          next_s.tx_cnt = s.tx_cnt + 5'h01;
          if (s.tx_cnt == hdsp_pkg::BIT_LAST) begin
            next_s.tx_cnt = '0;
            next_s.tx_st  = hdsp_pkg::TX_STOP;
          end
        end
        hdsp_pkg::TX_STOP: begin
          next_s.tx_cnt = s.tx_cnt + 5'h01;
          if (s.tx_cnt == stop_last) begin
            next_s.tx_cnt = '0;
            next_s.tx_st  = hdsp_pkg::TX_IDLE;
          end
        end
      endcase
    end

    // receiver: held idle while this node drives the shared pair
    if (s.ctrl.rts && !s.ctrl.loopback) begin
      next_s.rx_st    = hdsp_pkg::RX_IDLE;
      next_s.rx_armed = 1'b0;
    end else if (s.tick) begin
      unique case (s.rx_st)
        hdsp_pkg::RX_IDLE: begin
          // a break must return to mark before the next start is accepted
          if (rx_src) begin
            next_s.rx_armed = 1'b1;
          end else if (s.rx_armed) begin
            next_s.rx_st  = hdsp_pkg::RX_START;
            next_s.rx_cnt = '0;
          end
        end
        hdsp_pkg::RX_START: begin
          next_s.rx_cnt = s.rx_cnt + 5'h01;
          if (s.rx_cnt == hdsp_pkg::HALF_LAST) begin
            next_s.rx_cnt = '0;
            next_s.rx_idx = '0;
            next_s.rx_acc = 1'b0;
            next_s.rx_st  = rx_src ? hdsp_pkg::RX_IDLE : hdsp_pkg::RX_DATA;
          end
        end
        hdsp_pkg::RX_DATA: begin
          next_s.rx_cnt = s.rx_cnt + 5'h01;
          if (s.rx_cnt == hdsp_pkg::BIT_LAST) begin
            next_s.rx_cnt = '0;
            next_s.rx_sh  = {rx_src, s.rx_sh[7:1]};
            next_s.rx_acc = s.rx_acc ^ rx_src;
            next_s.rx_idx = s.rx_idx + 3'h1;
            next_s.rx_pbit = 1'b0;
            if (s.rx_idx == {1'b0, s.ctrl.wlen} + 3'h4) begin
              next_s.rx_st = par_on ? hdsp_pkg::RX_PAR : hdsp_pkg::RX_STOP;
            end
          end
        end
        hdsp_pkg::RX_PAR: begin
          next_s.rx_cnt = s.rx_cnt + 5'h01;
          if (s.rx_cnt == hdsp_pkg::BIT_LAST) begin
            next_s.rx_cnt  = '0;
            next_s.rx_pbit = rx_src;
            next_s.rx_st   = hdsp_pkg::RX_STOP;
          end
        end
        hdsp_pkg::RX_STOP: begin
          next_s.rx_cnt = s.rx_cnt + 5'h01;
          if (s.rx_cnt == hdsp_pkg::BIT_LAST) begin
            next_s.rx_cnt     = '0;
            next_s.rx_st      = hdsp_pkg::RX_IDLE;
            next_s.rx_armed   = rx_src;
            next_s.rx_data    = rx_word;
            flag_set.rx_valid = 1'b1;
            flag_set.overrun  = s.flags.rx_valid;
            flag_set.par_err  = par_on && ((s.rx_acc ^ s.rx_pbit) != par_odd);
            flag_set.frm_err  = !rx_src;
            // all-space character including the stop slot lasts past one character
            flag_set.brk      = rx_word == 8'h00 && !s.rx_pbit && !rx_src;
          end
        end
      endcase
    end

    // apb slave: no wait states, decode and read data prepared in setup
    next_s.pready  = psel && !penable && !s.pready;
    next_s.pslverr = 1'b0;
    next_s.prdata  = '0;
    if (psel && !penable) begin
      unique case (paddr)
        hdsp_pkg::OFF_DATA:   next_s.prdata = {24'h000000, s.rx_data};
        hdsp_pkg::OFF_CTRL:   next_s.prdata = {23'h0, s.ctrl};
        hdsp_pkg::OFF_DIV:    next_s.prdata = {16'h0000, s.div};
        hdsp_pkg::OFF_STATUS: begin
          next_s.prdata[hdsp_pkg::ST_RXVALID] = s.flags.rx_valid;
          next_s.prdata[hdsp_pkg::ST_TXBUSY]  = s.tx_st != hdsp_pkg::TX_IDLE;
          next_s.prdata[hdsp_pkg::ST_PARERR]  = s.flags.par_err;
          next_s.prdata[hdsp_pkg::ST_FRMERR]  = s.flags.frm_err;
          next_s.prdata[hdsp_pkg::ST_BREAK]   = s.flags.brk;
          next_s.prdata[hdsp_pkg::ST_OVERRUN] = s.flags.overrun;
        end
        default:              next_s.pslverr = 1'b1;
      endcase
    end

    if (wr) begin
      unique case (paddr)
        hdsp_pkg::OFF_DATA: begin
          // no holding buffer: a write while busy or while listening is dropped
          if (s.tx_st == hdsp_pkg::TX_IDLE && (s.ctrl.rts || s.ctrl.loopback)) begin
            next_s.tx_sh   = pwdata[7:0];
            next_s.tx_hold = pwdata[7:0];
            next_s.tx_par  = ^(pwdata[7:0] & hdsp_mask(s.ctrl.wlen)) ^ par_odd;
            next_s.tx_cnt  = '0;
            next_s.tx_st   = hdsp_pkg::TX_START;
          end
        end
        hdsp_pkg::OFF_CTRL:   next_s.ctrl = hdsp_pkg::hdsp_ctrl_type'(pwdata[8:0]);
        hdsp_pkg::OFF_DIV:    next_s.div  = pwdata[15:0];
        hdsp_pkg::OFF_STATUS: begin
          if (pwdata[hdsp_pkg::ST_PARERR])  next_s.flags.par_err = 1'b0;
          if (pwdata[hdsp_pkg::ST_FRMERR])  next_s.flags.frm_err = 1'b0;
          if (pwdata[hdsp_pkg::ST_BREAK])   next_s.flags.brk     = 1'b0;
          if (pwdata[hdsp_pkg::ST_OVERRUN]) next_s.flags.overrun = 1'b0;
        end
        default: ;
      endcase
    end
    if (rd && paddr == hdsp_pkg::OFF_DATA) begin
      next_s.flags.rx_valid = 1'b0;
    end
    // hardware set wins over a clear in the same cycle
    next_s.flags = next_s.flags | flag_set;

    // line bit follows the next state so bit and state change together
    unique case (next_s.tx_st)
      hdsp_pkg::TX_START: next_s.tx_bit = 1'b0;
      hdsp_pkg::TX_DATA:  next_s.tx_bit = next_s.tx_sh[0];
      hdsp_pkg::TX_PAR:   next_s.tx_bit = next_s.tx_par;
      default:            next_s.tx_bit = 1'b1;
    endcase
    if (next_s.ctrl.send_break) begin
      next_s.tx_bit = 1'b0;
    end
    next_s.line_tx  = next_s.ctrl.loopback ? 1'b1 : next_s.tx_bit;
    next_s.drive_en = next_s.ctrl.rts && !next_s.ctrl.loopback;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s          <= '0;
      s.ctrl     <= hdsp_pkg::CTRL_RESET;
      s.div      <= hdsp_pkg::DIV_RESET;
      s.tx_bit   <= 1'b1;
      s.rx_sync1 <= 1'b1;
      s.rx_sync2 <= 1'b1;
      s.line_tx  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end
  assign prdata        = s.prdata;
  assign pready        = s.pready;
  assign pslverr       = s.pslverr;
  assign line_tx       = s.line_tx;
  assign line_drive_en = s.drive_en;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence q_data_last;
    s.tx_st == hdsp_pkg::TX_DATA ##1 s.tx_st != hdsp_pkg::TX_DATA;
  endsequence
  property p_idle_mark;
    s.tx_st == hdsp_pkg::TX_IDLE && !s.ctrl.send_break |-> s.tx_bit;
  endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("idle line not at mark");
  property p_start_space;
    s.tx_st == hdsp_pkg::TX_IDLE ##1 s.tx_st == hdsp_pkg::TX_START |-> !s.tx_bit;
  endproperty
  a_start_space: assert property (p_start_space) else $error("start bit not space");
  property p_stop_mark;
    s.tx_st == hdsp_pkg::TX_STOP && !s.ctrl.send_break |-> s.tx_bit;
  endproperty
  a_stop_mark: assert property (p_stop_mark) else $error("stop bit not mark");
  property p_wlen;
    q_data_last |-> $past(s.tx_idx) == {1'b0, s.ctrl.wlen} + 3'h4;
  endproperty
  a_wlen: assert property (p_wlen) else $error("wrong data bit count");
  property p_none_skips;
    q_data_last |-> (par_on ? s.tx_st == hdsp_pkg::TX_PAR : s.tx_st == hdsp_pkg::TX_STOP);
  endproperty
  a_none_skips: assert property (p_none_skips) else $error("parity slot misplaced");
  property p_even;
    s.tx_st == hdsp_pkg::TX_PAR && !s.ctrl.send_break && s.ctrl.parity ==
      hdsp_pkg::HDSP_PAR_EVEN |-> !(^(s.tx_hold & hdsp_mask(s.ctrl.wlen)) ^ s.tx_bit);
  endproperty
  a_even: assert property (p_even) else $error("even parity wrong");
  property p_odd;
    s.tx_st == hdsp_pkg::TX_PAR && !s.ctrl.send_break && s.ctrl.parity ==
      hdsp_pkg::HDSP_PAR_ODD |-> (^(s.tx_hold & hdsp_mask(s.ctrl.wlen)) ^ s.tx_bit);
  endproperty
  a_odd: assert property (p_odd) else $error("odd parity wrong");
  property p_false_start;
    s.tick && s.rx_st == hdsp_pkg::RX_START && s.rx_cnt == hdsp_pkg::HALF_LAST && rx_src &&
      !(s.ctrl.rts && !s.ctrl.loopback) |=> s.rx_st == hdsp_pkg::RX_IDLE;
  endproperty
  a_false_start: assert property (p_false_start) else $error("false start kept");
  property p_framing;
    s.tick && s.rx_st == hdsp_pkg::RX_STOP && s.rx_cnt == hdsp_pkg::BIT_LAST && !rx_src &&
      !(s.ctrl.rts && !s.ctrl.loopback) |=> s.flags.frm_err;
  endproperty
  a_framing: assert property (p_framing) else $error("framing error missed");
  property p_half_duplex;
    s.drive_en |-> ##1 s.rx_st == hdsp_pkg::RX_IDLE || !s.drive_en;
  endproperty
  a_half_duplex: assert property (p_half_duplex) else $error("rx active while driving");
  property p_loop_cut;
    s.ctrl.loopback |-> s.line_tx && !s.drive_en;
  endproperty
  a_loop_cut: assert property (p_loop_cut) else $error("loopback reached the line");
  property p_rts_dir;
    $rose(s.ctrl.rts) && !s.ctrl.loopback |-> s.drive_en;
  endproperty
  a_rts_dir: assert property (p_rts_dir) else $error("rts did not drive");
endmodule

//--- tb/hdsp_node.sv
// partner model: a remote node on the shared half-duplex line
`timescale 1ns/10ps
module hdsp_node (
  input  wire logic pclk,
  input  wire logic line_lvl,
  output logic      node_en,
  output logic      node_bit
);
  int cyc = 0;

  initial begin
    node_en = 1'b0;
    node_bit = 1'b1;
  end
  always @(posedge pclk) cyc <= cyc + 1;

  // frame bits go out lsb first, then the line is released to its bias
  task automatic send(input logic [15:0] f, input int n, input int per);
    // idle mark first: the port only arms its receiver on a tick that sees mark
    repeat (8) @(posedge pclk);
    node_en <= 1'b1;
    for (int i = 0; i < n; i++) begin
      node_bit <= f[i];
      repeat (per) @(posedge pclk);
    end
    node_en <= 1'b0;
    node_bit <= ~f[n - 1];
  endtask

  // samples mid-bit from the start edge; t0 of -1 means no start ever came
  task automatic recv(output logic [15:0] f, input int n, input int per, output int t0);
    int w;
    f = 16'h0000;
    w = 0;
    t0 = -1;
    while (line_lvl !== 1'b0) begin
      if (w++ > 4000) return;
      @(posedge pclk);
    end
    t0 = cyc;
    repeat (per / 2) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      f[i] = line_lvl;
      if (i < n - 1) repeat (per) @(posedge pclk);
    end
  endtask
endmodule

//--- tb/hdsp_port_bench.sv
// self-checking bench: apb host on one side, a remote node on the shared line
`timescale 1ns/10ps
module hdsp_port_bench;
  localparam int PER = 80;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        line_tx;
  logic        line_drive_en;
  logic        node_en;
  logic        node_bit;
  logic        line_lvl;
  logic [31:0] rd;
  logic        err;
  int          num_errors = 0;
  int          checks_done = 0;
  int          exp_q[$];

  always #12.5 pclk = ~pclk;
  // biased line: reads mark whenever nobody drives it
  assign line_lvl = line_drive_en ? line_tx : (node_en ? node_bit : 1'b1);

  hdsp_port i_dut (
    .pclk          (pclk),
    .presetn       (presetn),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .line_rx       (line_lvl),
    .line_tx       (line_tx),
    .line_drive_en (line_drive_en)
  );
  hdsp_node i_node (.pclk(pclk), .line_lvl(line_lvl), .node_en(node_en), .node_bit(node_bit));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic fail_out;
    num_errors++;
    conclude();
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) fail_out();
  endtask

  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, hdsp_pkg::OFF_STATUS, 32'h0);
      n++;
    end while (rd[b] !== v && n < 2000);
    if (n >= 2000) fail_out();
  endtask

  // start, data lsb first, parity, stop bits; nb counts the bits before stop
  function automatic logic [15:0] frame(input logic [7:0] d, input int w, input int p,
                                        input int s, output int nb);
    logic [15:0] f;
    logic        par;
    f = 16'h0000;
    par = 1'b0;
    for (int i = 0; i < w + 5; i++) begin
      f[1 + i] = d[i];
      par ^= d[i];
    end
    nb = w + 6;
    if (p == 1 || p == 2) begin
      f[nb] = (p == 1) ? ~par : par;
      nb++;
    end
    f[nb] = 1'b1;
    f[nb + 1] = (s == 2);
    return f;
  endfunction

  initial begin
    logic [15:0] f;
    logic [15:0] g;
    logic [7:0]  dv;
    int          nb;
    int          t0;
    int          m;
    void'($urandom(32'h091E));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(negedge pclk);
    check(line_tx, 1);
    check(line_drive_en, 0);
    apb(0, hdsp_pkg::OFF_CTRL, 0);
    check(rd, 0);
    apb(0, hdsp_pkg::OFF_DIV, 0);
    check(rd, 32'(hdsp_pkg::DIV_RESET));
    apb(0, 12'h010, 0);
    check(err, 1);
    apb(1, hdsp_pkg::OFF_DIV, 1);
    for (int w = 0; w < 4; w++) begin
      for (int p = 0; p < 3; p++) begin
        for (int s = 0; s < 3; s++) begin
          dv = 8'($urandom);
          apb(1, hdsp_pkg::OFF_CTRL, 32'(w + 4 * p + 16 * s + 128));
          repeat (2) @(negedge pclk);
          check(line_drive_en, 1);
          f = frame(dv, w, p, s, nb);
          apb(1, hdsp_pkg::OFF_DATA, {24'h0, dv});
          i_node.recv(g, nb + 1 + (s == 2), PER, t0);
          if (t0 < 0) fail_out();
          check(g, f);
          poll(hdsp_pkg::ST_TXBUSY, 1'b0);
          m = i_node.cyc - t0 - nb * PER - (2 + s) * PER / 2;
          check(m > -5 && m < 9, 1);
        end
      end
    end
    apb(0, hdsp_pkg::OFF_STATUS, 0);
    check(rd[0], 0);
    // the receiver leg: the node talks while the port listens
    for (int w = 0; w < 4; w++) begin
      for (int p = 0; p < 3; p++) begin
        dv = 8'($urandom);
        apb(1, hdsp_pkg::OFF_CTRL, 32'(w + 20 * p));
        f = frame(dv, w, p, p, nb);
        exp_q.push_back(dv & ((1 << (w + 5)) - 1));
        i_node.send(f, nb + 1 + (p == 2), PER);
        poll(hdsp_pkg::ST_RXVALID, 1'b1);
        check(rd[5:2], 0);
        apb(0, hdsp_pkg::OFF_DATA, 0);
        check(rd, exp_q.pop_front());
      end
    end
    apb(1, hdsp_pkg::OFF_CTRL, 11);
    apb(1, hdsp_pkg::OFF_DATA, 32'h5A);
    repeat (40) @(negedge pclk);
    check(line_tx, 1);
    f = frame(8'hA5, 3, 2, 0, nb);
    f[nb - 1] = ~f[nb - 1];
    i_node.send(f, nb + 1, PER);
    poll(hdsp_pkg::ST_PARERR, 1'b1);
    check(rd[3], 0);
    f[nb - 1] = ~f[nb - 1];
    f[nb] = 1'b0;
    i_node.send(f, nb + 1, PER);
    poll(hdsp_pkg::ST_FRMERR, 1'b1);
    apb(1, hdsp_pkg::OFF_STATUS, 32'h3C);
    apb(0, hdsp_pkg::OFF_STATUS, 0);
    check(rd[5:2], 0);
    i_node.send(16'h0000, 1, 2000);
    poll(hdsp_pkg::ST_BREAK, 1'b1);
    check(rd[3], 1);
    apb(0, hdsp_pkg::OFF_DATA, 0);
    i_node.send(16'h0000, 1, 15);
    repeat (1200) @(posedge pclk);
    apb(0, hdsp_pkg::OFF_STATUS, 0);
    check(rd[0], 0);
    // loopback keeps the line quiet while the receiver hears the transmitter
    dv = 8'($urandom);
    apb(1, hdsp_pkg::OFF_CTRL, 395);
    apb(1, hdsp_pkg::OFF_DATA, {24'h0, dv});
    repeat (40) @(negedge pclk);
    check(line_tx, 1);
    check(line_drive_en, 0);
    poll(hdsp_pkg::ST_RXVALID, 1'b1);
    apb(0, hdsp_pkg::OFF_DATA, 0);
    check(rd, {24'h0, dv});
    apb(1, hdsp_pkg::OFF_CTRL, 192);
    repeat (2) @(negedge pclk);
    check(line_tx, 0);
    check(line_drive_en, 1);
    apb(1, hdsp_pkg::OFF_CTRL, 0);
    repeat (2) @(negedge pclk);
    check(line_tx, 1);
    check(line_drive_en, 0);
    conclude();
  end
endmodule
